// ---- logic/sbcf_pkg.sv ----
// shared constants, offsets and helpers for the screen block and cursor form bank
package sbcf_pkg;

    // ==========================================================
    // device register offsets
    localparam logic [15:0] SBCF_B1_LO = 16'h800B;
    localparam logic [15:0] SBCF_B1_HI = 16'h800C;
    localparam logic [15:0] SBCF_L1_LINES = 16'h800D;
    localparam logic [15:0] SBCF_B2_LO = 16'h800E;
    localparam logic [15:0] SBCF_B2_HI = 16'h800F;
    localparam logic [15:0] SBCF_L2_LINES = 16'h8010;
    localparam logic [15:0] SBCF_B3_LO = 16'h8011;
    localparam logic [15:0] SBCF_B3_HI = 16'h8012;
    localparam logic [15:0] SBCF_B4_LO = 16'h8013;
    localparam logic [15:0] SBCF_B4_HI = 16'h8014;
    localparam logic [15:0] SBCF_CUR_WIDTH = 16'h8015;
    localparam logic [15:0] SBCF_CUR_SHAPE = 16'h8016;
    localparam logic [15:0] SBCF_HI_STEP = 16'h0001;

    // ==========================================================
    // field positions and reset values
    localparam int SBCF_SHAPE_BIT = 7;
    localparam logic [15:0] SBCF_ADDR_RST = 16'h0000;
    localparam logic [7:0] SBCF_BYTE_RST = 8'h00;
    localparam logic [3:0] SBCF_NIB_RST = 4'h0;
    localparam logic [7:0] SBCF_ONE_LINE = 8'h01;

    // command code, value arbitrary
    localparam logic [7:0] SBCF_CSR_FORM_CMD = 8'hA1;

    // ==========================================================
    // host user port offsets
    localparam logic [3:0] SBCF_U_ADDR_VAL = 4'h0;
    localparam logic [3:0] SBCF_U_ADDR_GO = 4'h1;
    localparam logic [3:0] SBCF_U_LINES_GO = 4'h2;
    localparam logic [3:0] SBCF_U_CURSOR_GO = 4'h3;
    localparam logic [3:0] SBCF_U_CHAR_SIZE = 4'h4;
    localparam logic [3:0] SBCF_U_READ_GO = 4'h5;
    localparam logic [3:0] SBCF_U_READ_DATA = 4'h6;
    localparam logic [3:0] SBCF_U_STATUS = 4'h7;

    typedef enum logic [2:0] {
        SBCF_IDLE, SBCF_WR_LO, SBCF_WR_HI, SBCF_WR_L1, SBCF_WR_L2, SBCF_RD1, SBCF_RD2
    } sbcf_host_state_e;

    // ==========================================================
    // low byte address of a start address pair, block index 0..3
    function automatic logic [15:0] sbcf_start_lo(input logic [1:0] blk);
        case (blk)
            2'h0: sbcf_start_lo = SBCF_B1_LO;
            2'h1: sbcf_start_lo = SBCF_B2_LO;
            2'h2: sbcf_start_lo = SBCF_B3_LO;
            default: sbcf_start_lo = SBCF_B4_LO;
        endcase
    endfunction : sbcf_start_lo

    function automatic logic [15:0] sbcf_start_hi(input logic [1:0] blk);
        sbcf_start_hi = sbcf_start_lo(blk) + SBCF_HI_STEP;
    endfunction : sbcf_start_hi

    // smaller of two bytes
    function automatic logic [7:0] sbcf_min8(input logic [7:0] a, input logic [7:0] b);
        sbcf_min8 = (a < b) ? a : b;
    endfunction : sbcf_min8

    // distance between two bytes
    function automatic logic [7:0] sbcf_dist8(input logic [7:0] a, input logic [7:0] b);
        sbcf_dist8 = (a > b) ? 8'(a - b) : 8'(b - a);
    endfunction : sbcf_dist8

endpackage : sbcf_pkg

// ---- logic/sbcf_link_if.sv ----
// link between the host end and the configuration bank
`timescale 1ns/1ns
interface sbcf_link_if;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic cmd;
    logic [7:0] cmd_code;
    logic [15:0] cmd_params;

    modport host (
        output wr,
        output rd,
        output addr,
        output wdata,
        output cmd,
        output cmd_code,
        output cmd_params,
        input rdata
    );

    modport dev (
        input wr,
        input rd,
        input addr,
        input wdata,
        input cmd,
        input cmd_code,
        input cmd_params,
        output rdata
    );
endinterface : sbcf_link_if

// ---- logic/sbcf_device.sv ----
// screen block and cursor form configuration bank, device end
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
// ==========================================================
// Notes on behaviour
// - low byte first; address switches on high
// - single panel partition adds block three
// - single, unpartitioned: both counts frame plus one
// - single: block three lines is smaller count
// - dual: blocks three, four derived from frame count
// - dual: blank count gap to half frame
// - cursor form command loads both cursor registers
// - width field is pixels minus one
// - host keeps width within character width
// - shape bit: 0 underscore, 1 block
// - graphics mode needs block cursor
// - underscore: vertical field is underline row
// - block: vertical field is height minus one
// - host keeps height within character height
// - line count registers hold lines minus one
module sbcf_device
    import sbcf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    sbcf_link_if.dev link,
    input wire logic dual_panel_sel,
    input wire logic [7:0] frame_line_count,
    output logic [15:0] block_one_start_address,
    output logic [15:0] block_two_start_address,
    output logic [15:0] block_three_start_address,
    output logic [15:0] block_four_start_address,
    output logic [7:0] layer_one_block_lines,
    output logic [7:0] layer_two_block_lines,
    output logic [7:0] block_three_lines,
    output logic [7:0] block_four_lines,
    output logic block_three_active,
    output logic [7:0] layer_one_blank_lines,
    output logic [7:0] layer_two_blank_lines,
    output logic [3:0] cursor_width,
    output logic cursor_shape_select,
    output logic [3:0] cursor_vertical_field,
    output logic [3:0] cursor_underline_row,
    output logic [3:0] cursor_block_height
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [3:0][15:0] start_addr;
        logic [3:0][7:0] lo_shadow;
        logic [7:0] lay1_lines;
        logic [7:0] lay2_lines;
        logic [3:0] cur_width;
        logic cur_shape;
        logic [3:0] cur_vert;
        logic [7:0] rdata;
        logic [7:0] blk3_lines;
        logic [7:0] blk4_lines;
        logic blk3_active;
        logic [7:0] blank1;
        logic [7:0] blank2;
        logic [3:0] ul_row;
        logic [3:0] blk_height;
    } sbcf_dev_s;

    sbcf_dev_s st_ff;
    sbcf_dev_s nxt_st;

    // ==========================================================
    // next state
    always_comb begin
        logic [7:0] smaller;
        logic [8:0] frame_plus;
        logic [7:0] half_frame;
        smaller = sbcf_min8(st_ff.lay1_lines, st_ff.lay2_lines);
        frame_plus = {1'b0, frame_line_count} + 9'h001;
        half_frame = frame_plus[8:1];
        nxt_st = st_ff;
        nxt_st.rdata = SBCF_BYTE_RST;

        // register writes
        if (link.wr) begin
            for (int i = 0; i < 4; i++) begin
                if (link.addr == sbcf_start_lo(2'(i))) begin
                    nxt_st.lo_shadow[i] = link.wdata;
                end else if (link.addr == sbcf_start_hi(2'(i))) begin
                    nxt_st.start_addr[i] = {link.wdata, st_ff.lo_shadow[i]};
                end
            end
            if (link.addr == SBCF_L1_LINES) begin
                nxt_st.lay1_lines = link.wdata;
            end else if (link.addr == SBCF_L2_LINES) begin
                nxt_st.lay2_lines = link.wdata;
            end else if (link.addr == SBCF_CUR_WIDTH) begin
                nxt_st.cur_width = link.wdata[3:0];
            end else if (link.addr == SBCF_CUR_SHAPE) begin
                nxt_st.cur_shape = link.wdata[SBCF_SHAPE_BIT];
                nxt_st.cur_vert = link.wdata[3:0];
            end
        end

        // indirect cursor form command
        if (link.cmd && link.cmd_code == SBCF_CSR_FORM_CMD) begin
            nxt_st.cur_width = link.cmd_params[3:0];
            nxt_st.cur_shape = link.cmd_params[8 + SBCF_SHAPE_BIT];
            nxt_st.cur_vert = link.cmd_params[11:8];
        end

        // register reads, data in the next cycle
        if (link.rd) begin
            for (int i = 0; i < 4; i++) begin
                if (link.addr == sbcf_start_lo(2'(i))) begin
                    nxt_st.rdata = st_ff.lo_shadow[i];
                end else if (link.addr == sbcf_start_hi(2'(i))) begin
                    nxt_st.rdata = st_ff.start_addr[i][15:8];
                end
            end
            if (link.addr == SBCF_L1_LINES) begin
                nxt_st.rdata = st_ff.lay1_lines;
            end else if (link.addr == SBCF_L2_LINES) begin
                nxt_st.rdata = st_ff.lay2_lines;
            end else if (link.addr == SBCF_CUR_WIDTH) begin
                nxt_st.rdata = {4'h0, st_ff.cur_width};
            end else if (link.addr == SBCF_CUR_SHAPE) begin
                nxt_st.rdata = {st_ff.cur_shape, 3'h0, st_ff.cur_vert};
            end
        end

        // derived block sizes and blanking
        if (dual_panel_sel) begin
            nxt_st.blk3_lines = 8'(frame_line_count >> 1);
            nxt_st.blk4_lines = 8'(frame_line_count >> 1);
            nxt_st.blk3_active = 1'b1;
            nxt_st.blank1 = sbcf_dist8(st_ff.lay1_lines, half_frame);
            nxt_st.blank2 = sbcf_dist8(st_ff.lay2_lines, half_frame);
        end else begin
            nxt_st.blk3_lines = smaller;
            nxt_st.blk4_lines = SBCF_BYTE_RST;
            nxt_st.blk3_active = (smaller < frame_line_count);
            nxt_st.blank1 = SBCF_BYTE_RST;
            nxt_st.blank2 = SBCF_BYTE_RST;
        end

        // cursor vertical field meaning by shape
        nxt_st.ul_row = st_ff.cur_shape ? SBCF_NIB_RST : st_ff.cur_vert;
        nxt_st.blk_height = st_ff.cur_shape ? st_ff.cur_vert : SBCF_NIB_RST;
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff.start_addr <= {4{SBCF_ADDR_RST}};
            st_ff.lo_shadow <= {4{SBCF_BYTE_RST}};
            st_ff.lay1_lines <= SBCF_BYTE_RST;
            st_ff.lay2_lines <= SBCF_BYTE_RST;
            st_ff.cur_width <= SBCF_NIB_RST;
            st_ff.cur_shape <= 1'b0;
            st_ff.cur_vert <= SBCF_NIB_RST;
            st_ff.rdata <= SBCF_BYTE_RST;
            st_ff.blk3_lines <= SBCF_BYTE_RST;
            st_ff.blk4_lines <= SBCF_BYTE_RST;
            st_ff.blk3_active <= 1'b0;
            st_ff.blank1 <= SBCF_BYTE_RST;
            st_ff.blank2 <= SBCF_BYTE_RST;
            st_ff.ul_row <= SBCF_NIB_RST;
            st_ff.blk_height <= SBCF_NIB_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign link.rdata = st_ff.rdata;
    assign block_one_start_address = st_ff.start_addr[0];
    assign block_two_start_address = st_ff.start_addr[1];
    assign block_three_start_address = st_ff.start_addr[2];
    assign block_four_start_address = st_ff.start_addr[3];
    assign layer_one_block_lines = st_ff.lay1_lines;
    assign layer_two_block_lines = st_ff.lay2_lines;
    assign block_three_lines = st_ff.blk3_lines;
    assign block_four_lines = st_ff.blk4_lines;
    assign block_three_active = st_ff.blk3_active;
    assign layer_one_blank_lines = st_ff.blank1;
    assign layer_two_blank_lines = st_ff.blank2;
    assign cursor_width = st_ff.cur_width;
    assign cursor_shape_select = st_ff.cur_shape;
    assign cursor_vertical_field = st_ff.cur_vert;
    assign cursor_underline_row = st_ff.ul_row;
    assign cursor_block_height = st_ff.blk_height;

endmodule : sbcf_device

// ---- logic/sbcf_host.sv ----
// host end: sequences configuration writes and the cursor form command
`timescale 1ns/1ns
module sbcf_host
    import sbcf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    sbcf_link_if.host link,
    input wire logic [3:0] uaddr,
    input wire logic [15:0] uwdata,
    input wire logic uwr,
    input wire logic urd,
    output logic [15:0] urdata
);

    // ==========================================================
    // state
    typedef struct packed {
        sbcf_host_state_e state;
        logic [15:0] addr_val;
        logic [1:0] blk;
        logic [7:0] lines;
        logic [3:0] hchar;
        logic [3:0] vchar;
        logic [7:0] rd_data;
        logic l_wr;
        logic l_rd;
        logic [15:0] l_addr;
        logic [7:0] l_wdata;
        logic l_cmd;
        logic [15:0] l_params;
        logic [15:0] urdata;
    } sbcf_host_s;

    sbcf_host_s st_ff;
    sbcf_host_s nxt_st;

    // ==========================================================
    // next state
    always_comb begin
        logic [3:0] width;
        logic [3:0] vert;
        width = (uwdata[3:0] > st_ff.hchar) ? st_ff.hchar : uwdata[3:0];
        vert = (uwdata[7:4] > st_ff.vchar) ? st_ff.vchar : uwdata[7:4];
        nxt_st = st_ff;
        nxt_st.l_wr = 1'b0;
        nxt_st.l_rd = 1'b0;
        nxt_st.l_cmd = 1'b0;
        nxt_st.urdata = 16'h0000;

        if (urd) begin
            if (uaddr == SBCF_U_ADDR_VAL) begin
                nxt_st.urdata = st_ff.addr_val;
            end else if (uaddr == SBCF_U_CHAR_SIZE) begin
                nxt_st.urdata = {8'h00, st_ff.vchar, st_ff.hchar};
            end else if (uaddr == SBCF_U_READ_DATA) begin
                nxt_st.urdata = {8'h00, st_ff.rd_data};
            end else if (uaddr == SBCF_U_STATUS) begin
                nxt_st.urdata = {15'h0000, st_ff.state != SBCF_IDLE};
            end
        end

        if (uwr && uaddr == SBCF_U_ADDR_VAL) begin
            nxt_st.addr_val = uwdata;
        end else if (uwr && uaddr == SBCF_U_CHAR_SIZE) begin
            nxt_st.hchar = uwdata[3:0];
            nxt_st.vchar = uwdata[7:4];
        end

        case (st_ff.state)
            SBCF_IDLE: begin
                if (uwr && uaddr == SBCF_U_ADDR_GO) begin
                    nxt_st.blk = uwdata[1:0];
                    nxt_st.state = SBCF_WR_LO;
                end else if (uwr && uaddr == SBCF_U_LINES_GO) begin
                    if (uwdata[8]) begin
                        nxt_st.lines = 8'({1'b0, uwdata[7:1]} + SBCF_ONE_LINE);
                    end else begin
                        nxt_st.lines = 8'(uwdata[7:0] + SBCF_ONE_LINE);
                    end
                    nxt_st.state = SBCF_WR_L1;
                end else if (uwr && uaddr == SBCF_U_CURSOR_GO) begin
                    nxt_st.l_cmd = 1'b1;
                    nxt_st.l_params = {uwdata[8] | uwdata[9], 3'h0, vert, 4'h0, width};
                end else if (uwr && uaddr == SBCF_U_READ_GO) begin
                    nxt_st.l_rd = 1'b1;
                    nxt_st.l_addr = uwdata;
                    nxt_st.state = SBCF_RD1;
                end
            end
            SBCF_WR_LO: begin
                nxt_st.l_wr = 1'b1;
                nxt_st.l_addr = sbcf_start_lo(st_ff.blk);
                nxt_st.l_wdata = st_ff.addr_val[7:0];
                nxt_st.state = SBCF_WR_HI;
            end
            SBCF_WR_HI: begin
                nxt_st.l_wr = 1'b1;
                nxt_st.l_addr = sbcf_start_hi(st_ff.blk);
                nxt_st.l_wdata = st_ff.addr_val[15:8];
                nxt_st.state = SBCF_IDLE;
            end
            SBCF_WR_L1: begin
                nxt_st.l_wr = 1'b1;
                nxt_st.l_addr = SBCF_L1_LINES;
                nxt_st.l_wdata = st_ff.lines;
                nxt_st.state = SBCF_WR_L2;
            end
            SBCF_WR_L2: begin
                nxt_st.l_wr = 1'b1;
                nxt_st.l_addr = SBCF_L2_LINES;
                nxt_st.l_wdata = st_ff.lines;
                nxt_st.state = SBCF_IDLE;
            end
            SBCF_RD1: begin
                nxt_st.state = SBCF_RD2;
            end
            SBCF_RD2: begin
                nxt_st.rd_data = link.rdata;
                nxt_st.state = SBCF_IDLE;
            end
            default: begin
                nxt_st.state = SBCF_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.state <= SBCF_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.wr = st_ff.l_wr;
    assign link.rd = st_ff.l_rd;
    assign link.addr = st_ff.l_addr;
    assign link.wdata = st_ff.l_wdata;
    assign link.cmd = st_ff.l_cmd;
    assign link.cmd_code = SBCF_CSR_FORM_CMD;
    assign link.cmd_params = st_ff.l_params;
    assign urdata = st_ff.urdata;

endmodule : sbcf_host

// ---- tb/sbcf_checker.sv ----
// link protocol checker for the screen block and cursor form bank
`timescale 1ns/1ns
module sbcf_checker
    import sbcf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic cmd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_params
);
    // ==========================================================
    // address decode helpers
    wire logic lo_sel = (addr == SBCF_B1_LO) || (addr == SBCF_B2_LO) ||
        (addr == SBCF_B3_LO) || (addr == SBCF_B4_LO);
    wire logic hi_sel = (addr == SBCF_B1_HI) || (addr == SBCF_B2_HI) ||
        (addr == SBCF_B3_HI) || (addr == SBCF_B4_HI);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // assertions
    a_lo_then_hi: assert property (wr && lo_sel |=> wr && hi_sel && addr == $past(addr) + 16'h0001)
        else $error("low byte write not followed by its high byte");
    a_hi_after_lo: assert property (wr && hi_sel |-> $past(wr) && $past(addr) == addr - 16'h0001)
        else $error("high byte write without preceding low byte");
    a_lines_pair: assert property (wr && addr == SBCF_L1_LINES |=> wr && addr == SBCF_L2_LINES && wdata == $past(wdata))
        else $error("layer line counts not written as an equal pair");
    a_width_read_zero: assert property (rd && addr == SBCF_CUR_WIDTH |=> rdata[7:4] == 4'h0)
        else $error("cursor width unused bits not zero");
    a_shape_read_zero: assert property (rd && addr == SBCF_CUR_SHAPE |=> rdata[6:4] == 3'h0)
        else $error("cursor shape unused bits not zero");
    a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_cmd_code: assert property (cmd |-> cmd_code == SBCF_CSR_FORM_CMD)
        else $error("cursor command with wrong code");
    a_cmd_single: assert property (cmd |=> !cmd ##1 !cmd)
        else $error("cursor command strobe longer than one cycle");

    c_hi_write: cover property (wr && hi_sel);
    c_cmd: cover property (cmd && cmd_params[15]);
    c_shape_read: cover property (rd && addr == SBCF_CUR_SHAPE);
endmodule : sbcf_checker

// ---- tb/test_screen_block_cursor_form_config.sv ----
// self-checking bench joining host end and device end
`timescale 1ns/1ns
module test_screen_block_cursor_form_config
    import sbcf_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] uaddr = 4'h0;
    logic [15:0] uwdata = 16'h0000;
    logic uwr = 1'b0;
    logic urd = 1'b0;
    logic [15:0] urdata;
    logic dual_panel_sel = 1'b0;
    logic [7:0] frame_line_count = 8'h00;
    logic [15:0] sa [4];
    logic [7:0] l1, l2, b3, b4, bk1, bk2;
    logic b3_act, shp;
    logic [3:0] cw, cv, crow, chgt;
    logic [15:0] lo_tab [4] = '{SBCF_B1_LO, SBCF_B2_LO, SBCF_B3_LO, SBCF_B4_LO};
    integer seed = 32'h0354;
    int bad_count = 0;
    int total_checks = 0;

    always #5 mclk = ~mclk;

    sbcf_link_if link();
    sbcf_host sbcf_host_i (.mclk(mclk), .rst(rst), .link(link), .uaddr(uaddr), .uwdata(uwdata),
        .uwr(uwr), .urd(urd), .urdata(urdata));
    sbcf_device sbcf_device_i (.mclk(mclk), .rst(rst), .link(link),
        .dual_panel_sel(dual_panel_sel), .frame_line_count(frame_line_count),
        .block_one_start_address(sa[0]), .block_two_start_address(sa[1]),
        .block_three_start_address(sa[2]), .block_four_start_address(sa[3]),
        .layer_one_block_lines(l1), .layer_two_block_lines(l2), .block_three_lines(b3),
        .block_four_lines(b4), .block_three_active(b3_act), .layer_one_blank_lines(bk1),
        .layer_two_blank_lines(bk2), .cursor_width(cw), .cursor_shape_select(shp),
        .cursor_vertical_field(cv), .cursor_underline_row(crow), .cursor_block_height(chgt));
    sbcf_checker sbcf_checker_i (.mclk(mclk), .rst(rst), .wr(link.wr), .rd(link.rd),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .cmd(link.cmd),
        .cmd_code(link.cmd_code), .cmd_params(link.cmd_params));

    // ==========================================================
    // expectations
    function automatic logic [7:0] exp_lines(input logic [7:0] f, input logic d);
        exp_lines = d ? 8'((f >> 1) + 8'h01) : 8'(f + 8'h01);
    endfunction : exp_lines

    function automatic logic [7:0] exp_blank(input logic [7:0] l, input logic [7:0] f,
        input logic d);
        logic [8:0] h;
        h = (9'(f) + 9'h001) >> 1;
        exp_blank = !d ? 8'h00 : (9'(l) > h) ? 8'(9'(l) - h) : 8'(h - 9'(l));
    endfunction : exp_blank

    // ==========================================================
    // port tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic uw(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        uaddr <= a;
        uwdata <= d;
        uwr <= 1'b1;
        @(posedge mclk);
        uwr <= 1'b0;
    endtask : uw

    task automatic ur(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        uaddr <= a;
        urd <= 1'b1;
        @(posedge mclk);
        urd <= 1'b0;
        @(negedge mclk);
        d = urdata;
    endtask : ur

    task automatic wait_idle();
        logic [15:0] s;
        for (int n = 0; n < 20; n++) begin
            ur(SBCF_U_STATUS, s);
            if (s[0] === 1'b0) break;
            if (n == 19) chk(s, 16'h0000, "busy stuck");
        end
    endtask : wait_idle

    task automatic rd_link(input logic [15:0] a, output logic [15:0] d);
        uw(SBCF_U_READ_GO, a);
        wait_idle();
        ur(SBCF_U_READ_DATA, d);
    endtask : rd_link

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        #200000;
        bad_count++;
        complete_run();
    end

    // ==========================================================
    // tests
    initial begin
        logic [15:0] v, old, d;
        logic [7:0] fp, fd, le;
        logic [3:0] w, vt, hc, vc, ew, ev;
        logic s, g, dl;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd_link(SBCF_CUR_WIDTH, d);
        chk(d, 16'h0000, "width reset");
        rd_link(SBCF_CUR_SHAPE, d);
        chk(d, 16'h0000, "shape reset");
        rd_link(16'h8017, d);
        chk(d, 16'h0000, "unmapped read");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            old = sa[i % 4];
            uw(SBCF_U_ADDR_VAL, v);
            ur(SBCF_U_ADDR_VAL, d);
            chk(d, v, "addr value readback");
            uw(SBCF_U_ADDR_GO, 16'(i % 4));
            for (int n = 0; n < 10 && link.wr !== 1'b1; n++) @(negedge mclk);
            chk(sa[i % 4], old, "start addr during low");
            @(negedge mclk);
            chk(sa[i % 4], old, "start addr during high");
            @(negedge mclk);
            chk(sa[i % 4], v, "start addr loaded");
            wait_idle();
            rd_link(lo_tab[i % 4], d);
            chk(d, {8'h00, v[7:0]}, "shadow low");
            rd_link(lo_tab[i % 4] + 16'h0001, d);
            chk(d, {8'h00, v[15:8]}, "high byte");
        end
        $display("test start address done");
        for (int i = 0; i < 10; i++) begin
            dl = i[0];
            fp = (i == 2) ? 8'hFF : (i == 3) ? 8'h00 : 8'($random(seed));
            fd = 8'($random(seed));
            @(posedge mclk);
            dual_panel_sel <= dl;
            frame_line_count <= fd;
            uw(SBCF_U_LINES_GO, {7'h00, dl, fp});
            wait_idle();
            repeat (4) @(posedge mclk);
            @(negedge mclk);
            le = exp_lines(fp, dl);
            chk(l1, le, "layer one lines");
            chk(l2, le, "layer two lines");
            chk(b3, dl ? fd >> 1 : le, "block three lines");
            chk(b4, dl ? fd >> 1 : 8'h00, "block four lines");
            chk(b3_act, dl ? 1'b1 : (le < fd), "partition");
            chk(bk1, exp_blank(le, fd, dl), "blank one");
            chk(bk2, exp_blank(le, fd, dl), "blank two");
            rd_link(SBCF_L1_LINES, d);
            chk(d, {8'h00, le}, "lines readback");
        end
        $display("test line counts done");
        for (int i = 0; i < 14; i++) begin
            {vc, hc, vt, w} = 16'($random(seed));
            s = (i < 2) ? 1'b0 : 1'($random(seed));
            g = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($random(seed));
            ew = (w > hc) ? hc : w;
            ev = (vt > vc) ? vc : vt;
            uw(SBCF_U_CHAR_SIZE, {8'h00, vc, hc});
            ur(SBCF_U_CHAR_SIZE, d);
            chk(d, {8'h00, vc, hc}, "char size readback");
            uw(SBCF_U_CURSOR_GO, {6'h00, g, s, vt, w});
            repeat (4) @(posedge mclk);
            @(negedge mclk);
            chk(cw, ew, "cursor width");
            chk(shp, s | g, "cursor shape");
            chk(cv, ev, "cursor vertical");
            chk(crow, (s | g) ? 4'h0 : ev, "underline row");
            chk(chgt, (s | g) ? ev : 4'h0, "block height");
            rd_link(SBCF_CUR_WIDTH, d);
            chk(d, {12'h000, ew}, "width readback");
            rd_link(SBCF_CUR_SHAPE, d);
            chk(d, {8'h00, s | g, 3'h0, ev}, "shape readback");
        end
        $display("test cursor form done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk(sa[0], 16'h0000, "start addr after reset");
        chk({cw, shp, cv}, 16'h0000, "cursor after reset");
        chk(l1, 8'h00, "lines after reset");
        $display("test mid reset done");
        complete_run();
    end
endmodule : test_screen_block_cursor_form_config
